// ### design/ccie_regs.svh
`ifndef CCIE_REGS_SVH
`define CCIE_REGS_SVH

// Instruction word layout
`define CCIE_WORD_W 14
`define CCIE_ADDR_W 7
`define CCIE_DATA_W 8
`define CCIE_REG_DEPTH 128
`define CCIE_ADDR_LSB 0
`define CCIE_ADDR_MSB 6
`define CCIE_DEST_BIT 7

// Opcode patterns
`define CCIE_CLEAR_REG_PAT 7'h03
`define CCIE_CLEAR_ACC_PAT 7'h02
`define CCIE_CLEAR_PAT_MSB 13
`define CCIE_CLEAR_PAT_LSB 7
`define CCIE_WATCHDOG_CLR_WORD 14'h0064
`define CCIE_INVERT_PAT 6'h09
`define CCIE_INVERT_PAT_MSB 13
`define CCIE_INVERT_PAT_LSB 8

// Reset and result values
`define CCIE_ZERO_BYTE 8'h00
`define CCIE_ACC_RESET 8'h00
`define CCIE_DEST_ACC 1'h0
`define CCIE_DEST_REG 1'h1

`endif

// ### design/ccie_pkg.sv
`default_nettype none
`include "ccie_regs.svh"

package ccie_pkg;

    typedef enum logic [2:0] {
        CCIE_OP_NONE = 3'b000,
        CCIE_OP_CLEAR_REG = 3'b001,
        CCIE_OP_CLEAR_ACC = 3'b010,
        CCIE_OP_WATCHDOG_CLEAR = 3'b011,
        CCIE_OP_INVERT_REG = 3'b100
    } ccie_op_t;

    typedef enum logic [1:0] {
        CCIE_PH_Q1 = 2'b00,
        CCIE_PH_Q2 = 2'b01,
        CCIE_PH_Q3 = 2'b10,
        CCIE_PH_Q4 = 2'b11
    } ccie_phase_t;

    typedef struct packed {
        ccie_op_t op;
        logic dest;
        logic [`CCIE_ADDR_W-1:0] addr;
    } ccie_instr_t;

    typedef struct packed {
        logic en;
        logic [`CCIE_ADDR_W-1:0] addr;
        logic [`CCIE_DATA_W-1:0] data;
    } ccie_wr_t;

endpackage

`default_nettype wire

// ### design/ccie_regfile.sv
`default_nettype none
`include "ccie_regs.svh"

module ccie_regfile
#(
    parameter int DATA_W = `CCIE_DATA_W,
    parameter int ADDR_W = `CCIE_ADDR_W,
    parameter int DEPTH = `CCIE_REG_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rdEn,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData
);

    logic [DATA_W-1:0] mem [DEPTH];

    // Contents are not reset; read data is registered
    always_ff @(posedge core_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        if (rdEn)
        begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

`default_nettype wire

// ### design/ccie_exec.sv
`default_nettype none
`include "ccie_regs.svh"

module ccie_exec
    import ccie_pkg::*;
#(
    parameter int DATA_W = `CCIE_DATA_W,
    parameter int ADDR_W = `CCIE_ADDR_W
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [`CCIE_WORD_W-1:0] instrWord,
    input wire logic timeoutEvent,
    input wire logic sleepEvent,
    output logic instrReady,
    output ccie_phase_t phase,
    output logic [DATA_W-1:0] accumulator,
    output logic zeroFlag,
    output logic timeoutFlagN,
    output logic powerdownFlagN,
    output logic watchdogClear,
    output logic prescalerClear,
    output ccie_wr_t regWrite
);

    // Opcode decode of one instruction word
    function automatic ccie_instr_t ccieDecode(input logic [`CCIE_WORD_W-1:0] word);
        ccie_instr_t d;
        d.op = CCIE_OP_NONE;
        d.dest = word[`CCIE_DEST_BIT];
        d.addr = word[`CCIE_ADDR_MSB:`CCIE_ADDR_LSB];
        if (word[`CCIE_CLEAR_PAT_MSB:`CCIE_CLEAR_PAT_LSB] == `CCIE_CLEAR_REG_PAT)
        begin
            d.op = CCIE_OP_CLEAR_REG;
        end
        else if (word[`CCIE_CLEAR_PAT_MSB:`CCIE_CLEAR_PAT_LSB] == `CCIE_CLEAR_ACC_PAT)
        begin
            d.op = CCIE_OP_CLEAR_ACC;
        end
        else if (word == `CCIE_WATCHDOG_CLR_WORD)
        begin
            d.op = CCIE_OP_WATCHDOG_CLEAR;
        end
        else if (word[`CCIE_INVERT_PAT_MSB:`CCIE_INVERT_PAT_LSB] == `CCIE_INVERT_PAT)
        begin
            d.op = CCIE_OP_INVERT_REG;
        end
        return d;
    endfunction

    ccie_instr_t current;
    ccie_phase_t next_phase;
    logic [DATA_W-1:0] rdData;

    wire ccie_instr_t decoded = ccieDecode(instrWord);
    wire logic inQ1 = (phase == CCIE_PH_Q1);
    wire logic inQ2 = (phase == CCIE_PH_Q2);
    wire logic inQ3 = (phase == CCIE_PH_Q3);
    wire logic inQ4 = (phase == CCIE_PH_Q4);

    wire logic isClearReg = (current.op == CCIE_OP_CLEAR_REG);
    wire logic isClearAcc = (current.op == CCIE_OP_CLEAR_ACC);
    wire logic isWatchdog = (current.op == CCIE_OP_WATCHDOG_CLEAR);
    wire logic isInvert = (current.op == CCIE_OP_INVERT_REG);

    // Register read in Q2 only for ops with a register operand
    wire logic readNeeded = isClearReg || isInvert;
    wire logic readStrobe = inQ2 && readNeeded;

    // Process step of Q3
    wire logic [DATA_W-1:0] result = isInvert ? ~rdData : `CCIE_ZERO_BYTE;
    wire logic resultZero = (result == `CCIE_ZERO_BYTE);

    // Destination selection
    wire logic toRegister = isClearReg || (isInvert && current.dest == `CCIE_DEST_REG);
    wire logic toAccumulator = isClearAcc || (isInvert && current.dest == `CCIE_DEST_ACC);
    wire logic zeroUpdate = isClearReg || isClearAcc || isInvert;

    // Q1..Q4 sequencing, one phase per clock
    always_comb
    begin
        case (phase)
            CCIE_PH_Q1: next_phase = CCIE_PH_Q2;
            CCIE_PH_Q2: next_phase = CCIE_PH_Q3;
            CCIE_PH_Q3: next_phase = CCIE_PH_Q4;
            CCIE_PH_Q4: next_phase = CCIE_PH_Q1;
            default: next_phase = CCIE_PH_Q1;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase <= CCIE_PH_Q1;
            instrReady <= 1'b1;
        end
        else
        begin
            phase <= next_phase;
            instrReady <= (next_phase == CCIE_PH_Q1);
        end
    end

    // Decode step of Q1
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            current <= '0;
        end
        else if (inQ1)
        begin
            current <= instrValid ? decoded : '0;
        end
    end

    // Read only in Q2; a write lands at the edge ending Q4
    ccie_regfile #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W),
        .DEPTH(`CCIE_REG_DEPTH)
    ) u_regfile (
        .core_clk(core_clk),
        .rdEn(readStrobe),
        .rdAddr(current.addr),
        .rdData(rdData),
        .wrEn(regWrite.en),
        .wrAddr(regWrite.addr),
        .wrData(regWrite.data)
    );

    // Write request stands through Q4, lands at the Q4 edge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            regWrite <= '0;
        end
        else
        begin
            regWrite.en <= inQ3 && toRegister;
            regWrite.addr <= current.addr;
            regWrite.data <= result;
        end
    end

    // Watchdog clear pulses stand during Q4
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            watchdogClear <= 1'b0;
            prescalerClear <= 1'b0;
        end
        else
        begin
            watchdogClear <= inQ3 && isWatchdog;
            prescalerClear <= inQ3 && isWatchdog;
        end
    end

    // Accumulator and zero flag written at the Q4 edge
    // Operand and op hold still through Q4, so the result is final
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            accumulator <= `CCIE_ACC_RESET;
            zeroFlag <= 1'b0;
        end
        else if (inQ4)
        begin
            if (toAccumulator)
            begin
                accumulator <= regWrite.data;
            end
            if (zeroUpdate)
            begin
                zeroFlag <= resultZero;
            end
        end
    end

    // Active-low status flags; the instruction's set wins over an event clear
    // Events come from logic on this clock, so no synchroniser
    wire logic statusSet = inQ4 && isWatchdog;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            timeoutFlagN <= 1'b1;
            powerdownFlagN <= 1'b1;
        end
        else
        begin
            if (statusSet)
            begin
                timeoutFlagN <= 1'b1;
                powerdownFlagN <= 1'b1;
            end
            else
            begin
                if (timeoutEvent)
                begin
                    timeoutFlagN <= 1'b0;
                end
                if (sleepEvent)
                begin
                    powerdownFlagN <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### dv/ccie_exec_checker.sv
`default_nettype none
`include "ccie_regs.svh"
module ccie_exec_checker
    import ccie_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [`CCIE_WORD_W-1:0] instrWord,
    input wire logic timeoutEvent,
    input wire logic sleepEvent,
    input wire logic instrReady,
    input wire ccie_phase_t phase,
    input wire logic [`CCIE_DATA_W-1:0] accumulator,
    input wire logic zeroFlag,
    input wire logic timeoutFlagN,
    input wire logic powerdownFlagN,
    input wire logic watchdogClear,
    input wire logic prescalerClear,
    input wire ccie_wr_t regWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic take, takeClrReg, takeClrAcc, takeWdt, takeInv;
    logic [6:0] heldAddr;
    assign take = instrReady && instrValid;
    assign takeClrReg = take && instrWord[13:7] == `CCIE_CLEAR_REG_PAT;
    assign takeClrAcc = take && instrWord[13:7] == `CCIE_CLEAR_ACC_PAT;
    assign takeWdt = take && instrWord == `CCIE_WATCHDOG_CLR_WORD;
    assign takeInv = take && instrWord[13:8] == `CCIE_INVERT_PAT;
    // Address of the word taken last
    always_ff @(posedge core_clk)
    begin
        if (take)
        begin
            heldAddr <= instrWord[6:0];
        end
    end
    chk_ready_phase: assert property (instrReady == (phase == CCIE_PH_Q1))
        else $error("ready does not match first phase");
    chk_phase_walk: assert property (instrReady |=> phase == CCIE_PH_Q2 ##1 phase == CCIE_PH_Q3
        ##1 phase == CCIE_PH_Q4) else $error("phase sequence broken");
    chk_clear_reg: assert property (takeClrReg |-> ##3 regWrite.en && regWrite.addr == heldAddr
        && regWrite.data == 8'h00 ##1 zeroFlag) else $error("register clear wrong");
    chk_clear_acc: assert property (takeClrAcc |-> ##3 !regWrite.en
        ##1 accumulator == 8'h00 && zeroFlag) else $error("accumulator clear wrong");
    chk_watchdog_clear: assert property (takeWdt |-> ##3 watchdogClear && prescalerClear
        ##1 timeoutFlagN && powerdownFlagN) else $error("watchdog clear wrong");
    chk_pulse_pair: assert property (watchdogClear |-> prescalerClear && phase == CCIE_PH_Q4)
        else $error("watchdog pulses apart");
    chk_invert_reg: assert property (takeInv && instrWord[7] |-> ##3 regWrite.en
        && regWrite.addr == heldAddr ##1 zeroFlag == ($past(regWrite.data) == 8'h00))
        else $error("invert to register wrong");
    chk_invert_acc: assert property (takeInv && !instrWord[7] |-> ##3 !regWrite.en
        ##1 zeroFlag == (accumulator == 8'h00)) else $error("invert to accumulator wrong");
    chk_write_q4: assert property (regWrite.en |-> phase == CCIE_PH_Q4)
        else $error("write outside last phase");
    cover property (takeClrReg);
    cover property (takeInv && instrWord[7]);
    cover property (watchdogClear);
endmodule
bind ccie_exec ccie_exec_checker u_chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .timeoutEvent(timeoutEvent),
    .sleepEvent(sleepEvent),
    .instrReady(instrReady),
    .phase(phase),
    .accumulator(accumulator),
    .zeroFlag(zeroFlag),
    .timeoutFlagN(timeoutFlagN),
    .powerdownFlagN(powerdownFlagN),
    .watchdogClear(watchdogClear),
    .prescalerClear(prescalerClear),
    .regWrite(regWrite)
);
`default_nettype wire

// ### dv/clear_complement_instr_exec_tb.sv
`default_nettype none
`include "ccie_regs.svh"
module clear_complement_instr_exec_tb
    import ccie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, instrValid, timeoutEvent, sleepEvent;
    logic [13:0] instrWord;
    logic instrReady, zeroFlag, timeoutFlagN, powerdownFlagN, watchdogClear, prescalerClear;
    logic [7:0] accumulator;
    ccie_phase_t phase;
    ccie_wr_t regWrite;
    logic we, wc, pc;
    logic [6:0] wa;
    logic [7:0] wd;
    int n_errors = 0;
    int n_tests = 0;
    ccie_exec u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .instrValid(instrValid),
        .instrWord(instrWord),
        .timeoutEvent(timeoutEvent),
        .sleepEvent(sleepEvent),
        .instrReady(instrReady),
        .phase(phase),
        .accumulator(accumulator),
        .zeroFlag(zeroFlag),
        .timeoutFlagN(timeoutFlagN),
        .powerdownFlagN(powerdownFlagN),
        .watchdogClear(watchdogClear),
        .prescalerClear(prescalerClear),
        .regWrite(regWrite)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        if (g !== e) n_errors++;
    endtask
    // Offer one word in the first phase, capture the last-phase pulses
    task automatic exec(input logic [13:0] w);
        int n;
        n = 0;
        while (instrReady !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        instrValid = 1'b1;
        instrWord = w;
        @(negedge core_clk);
        instrValid = 1'b0;
        instrWord = 14'h0000;
        repeat (2) @(negedge core_clk);
        we = regWrite.en;
        wa = regWrite.addr;
        wd = regWrite.data;
        wc = watchdogClear;
        pc = prescalerClear;
        @(negedge core_clk);
    endtask
    task automatic t_clear_invert();
        exec({`CCIE_CLEAR_REG_PAT, 7'h7F});
        chk({we, wa, wd, zeroFlag}, {1'b1, 7'h7F, 8'h00, 1'b1});
        exec({`CCIE_INVERT_PAT, 1'b0, 7'h7F});
        chk({we, accumulator, zeroFlag}, {1'b0, 8'hFF, 1'b0});
        exec({`CCIE_INVERT_PAT, 1'b1, 7'h7F});
        chk({we, wa, wd, zeroFlag}, {1'b1, 7'h7F, 8'hFF, 1'b0});
        exec({`CCIE_INVERT_PAT, 1'b1, 7'h7F});
        chk({we, wd, zeroFlag}, {1'b1, 8'h00, 1'b1});
        exec({`CCIE_INVERT_PAT, 1'b0, 7'h7F});
        chk({we, accumulator, zeroFlag}, {1'b0, 8'hFF, 1'b0});
    endtask
    task automatic t_clear_acc();
        exec({`CCIE_CLEAR_ACC_PAT, 7'h55});
        chk({we, accumulator, zeroFlag}, {1'b0, 8'h00, 1'b1});
        exec({`CCIE_INVERT_PAT, 1'b0, 7'h7F});
        chk({we, accumulator, zeroFlag}, {1'b0, 8'hFF, 1'b0});
    endtask
    task automatic t_watchdog();
        timeoutEvent = 1'b1;
        sleepEvent = 1'b1;
        @(negedge core_clk);
        timeoutEvent = 1'b0;
        sleepEvent = 1'b0;
        @(negedge core_clk);
        chk({timeoutFlagN, powerdownFlagN}, 2'h0);
        exec(`CCIE_WATCHDOG_CLR_WORD);
        chk({we, wc, pc, timeoutFlagN, powerdownFlagN}, 5'h0F);
        exec(14'h3FFF);
        chk({we, wc, pc, accumulator}, 11'h0FF);
        instrWord = {`CCIE_CLEAR_ACC_PAT, 7'h00};
        repeat (4) @(negedge core_clk);
        instrWord = 14'h0000;
        repeat (4) @(negedge core_clk);
        chk({accumulator, zeroFlag}, {8'hFF, 1'b0});
    endtask
    task automatic results();
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge core_clk);
        n_errors++;
        results();
    end
    initial
    begin
        rst_n = 1'b0;
        instrValid = 1'b0;
        instrWord = 14'h0000;
        timeoutEvent = 1'b0;
        sleepEvent = 1'b0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        chk({instrReady, accumulator, zeroFlag, timeoutFlagN, powerdownFlagN}, 12'h803);
        t_clear_invert();
        t_clear_acc();
        t_watchdog();
        results();
    end
endmodule
`default_nettype wire
